/* File: src/melter_io_pkg.sv */
// Purpose: constants for the discrete command/status encoder of the melter
// Assumes: 250 MHz system clock, APB register access with 32-bit data
// Notes:   offsets are byte addresses; each register takes one aligned word
package melter_io_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ         = 250;
    localparam int unsigned SOAK_TIME_MS    = 1000;
    localparam int unsigned SOAK_CYCLES     = SOAK_TIME_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int unsigned ZONES           = 14;
    localparam int unsigned ADDR_W          = 8;
    localparam int unsigned EVENTS          = 5;

    // ------------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS         = 8'h00;
    localparam logic [7:0] STATUS_OFS       = 8'h04;
    localparam logic [7:0] DIAG_OFS         = 8'h08;
    localparam logic [7:0] IRQ_STATUS_OFS   = 8'h0c;
    localparam logic [7:0] IRQ_CLEAR_OFS    = 8'h10;
    localparam logic [7:0] IRQ_ENABLE_OFS   = 8'h14;

    // ------------------------------------------------------------------
    // control register fields
    // ------------------------------------------------------------------
    localparam int unsigned CTRL_AUTOSTART  = 0;
    localparam int unsigned CTRL_CHANGEOVER = 1;
    localparam int unsigned CTRL_PANEL_HEAT = 2;
    localparam int unsigned CTRL_PANEL_SETB = 3;
    localparam int unsigned CTRL_PANEL_PUMP = 4;
    localparam int unsigned CTRL_W          = 5;
    localparam logic [4:0]  CTRL_RESET      = 5'h00;

    // ------------------------------------------------------------------
    // interrupt event bits
    // ------------------------------------------------------------------
    localparam int unsigned EV_AT_TEMP      = 0;
    localparam int unsigned EV_ALARM        = 1;
    localparam int unsigned EV_DRUM_EMPTY   = 2;
    localparam int unsigned EV_CHANGEOVER   = 3;
    localparam int unsigned EV_EXT_CTRL     = 4;
    localparam logic [4:0]  IRQ_RESET       = 5'h00;

    // ------------------------------------------------------------------
    // output encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] RUN_IDLE         = 2'h0;
    localparam logic [1:0] RUN_HEAT_ON      = 2'h1;
    localparam logic [1:0] RUN_AT_TEMP      = 2'h2;
    localparam logic [1:0] RUN_PUMP_ON      = 2'h3;
    localparam logic [1:0] ERR_NONE         = 2'h0;
    localparam logic [1:0] ERR_DRUM_LOW     = 2'h1;
    localparam logic [1:0] ERR_DRUM_EMPTY   = 2'h2;
    localparam logic [1:0] ERR_ALARM        = 2'h3;

    typedef enum logic [1:0] {
        HEAT_OFF,
        HEAT_WARMUP,
        HEAT_SOAK,
        HEAT_ACTIVE
    } heat_state_t;

endpackage : melter_io_pkg

/* File: src/plc_discrete_io_status_encoder.sv */
// Purpose: discrete command inputs and status contacts toward an external controller
// Assumes: inputs synchronous to clk_i; zone and drum flags come from the zone control board
// Notes:   status contacts are 1 = closed; all open in reset and power-off

module plc_discrete_io_status_encoder #(
    parameter int unsigned SOAK_CYCLES = melter_io_pkg::SOAK_CYCLES
) (
    // clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rstn_i,
    // apb slave
    input  wire logic                              psel_i,
    input  wire logic                              penable_i,
    input  wire logic                              pwrite_i,
    input  wire logic [melter_io_pkg::ADDR_W-1:0]  paddr_i,
    input  wire logic [31:0]                       pwdata_i,
    output logic      [31:0]                       prdata_o,
    output logic                                   pready_o,
    output logic                                   pslverr_o,
    // command input connector
    input  wire logic                              heat_req_i,
    input  wire logic                              setback_req_i,
    input  wire logic                              pump_req_i,
    input  wire logic                              external_control_request_in_i,
    // zone control board
    input  wire logic [melter_io_pkg::ZONES-1:0]   zone_enabled_i,
    input  wire logic [melter_io_pkg::ZONES-1:0]   zone_in_window_i,
    input  wire logic [melter_io_pkg::ZONES-1:0]   zone_at_setpoint_i,
    input  wire logic [1:0]                        drum_low_i,
    input  wire logic [1:0]                        drum_empty_i,
    input  wire logic                              alarm_i,
    // status output connector
    output logic [1:0]                             run_state_o,
    output logic [1:0]                             error_state_o,
    // actuators
    output logic                                   heater_enable_o,
    output logic                                   setback_o,
    output logic                                   air_motor_enable_o,
    output logic                                   pump_on_o,
    output logic                                   active_unit_o,
    // interrupt
    output logic                                   irq_o
);

    // ------------------------------------------------------------------
    // registers and state
    // ------------------------------------------------------------------
    logic [melter_io_pkg::CTRL_W-1:0]  ctrl_reg;
    logic [melter_io_pkg::EVENTS-1:0]  irq_status_reg;
    logic [melter_io_pkg::EVENTS-1:0]  irq_status_next;
    logic [melter_io_pkg::EVENTS-1:0]  irq_enable_reg;
    logic [31:0]                       prdata_reg;
    logic                              pslverr_reg;
    melter_io_pkg::heat_state_t        state_reg;
    melter_io_pkg::heat_state_t        state_next;
    logic [31:0]                       soak_cnt_reg;
    logic                              pump_auto_reg;
    logic                              active_unit_reg;
    logic                              ext_reg;
    logic                              alarm_reg;
    logic                              empty_reg;
    logic                              at_temp_reg;
    logic [1:0]                        run_state_reg;
    logic [1:0]                        error_state_reg;
    logic                              heater_reg;
    logic                              setback_reg;
    logic                              air_reg;
    logic                              pump_reg;

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    wire logic setup_phase = psel_i & ~penable_i;
    wire logic access_wr   = psel_i & penable_i & pwrite_i;
    wire logic hit_ctrl    = hit(paddr_i, melter_io_pkg::CTRL_OFS);
    wire logic hit_status  = hit(paddr_i, melter_io_pkg::STATUS_OFS);
    wire logic hit_diag    = hit(paddr_i, melter_io_pkg::DIAG_OFS);
    wire logic hit_irqs    = hit(paddr_i, melter_io_pkg::IRQ_STATUS_OFS);
    wire logic hit_irqc    = hit(paddr_i, melter_io_pkg::IRQ_CLEAR_OFS);
    wire logic hit_irqe    = hit(paddr_i, melter_io_pkg::IRQ_ENABLE_OFS);
    wire logic mapped      = hit_ctrl | hit_status | hit_diag | hit_irqs | hit_irqc | hit_irqe;
    wire logic wr_ctrl     = access_wr & hit_ctrl;
    wire logic wr_irqc     = access_wr & hit_irqc;
    wire logic wr_irqe     = access_wr & hit_irqe;

    // ------------------------------------------------------------------
    // command selection
    // ------------------------------------------------------------------
    wire logic ext_ctrl     = external_control_request_in_i;
    wire logic heat_cmd     = ext_ctrl ? heat_req_i    : ctrl_reg[melter_io_pkg::CTRL_PANEL_HEAT];
    wire logic setback_cmd  = ext_ctrl ? setback_req_i : ctrl_reg[melter_io_pkg::CTRL_PANEL_SETB];
    wire logic manual_pump  = ext_ctrl ? pump_req_i    : ctrl_reg[melter_io_pkg::CTRL_PANEL_PUMP];
    wire logic autostart_en = ctrl_reg[melter_io_pkg::CTRL_AUTOSTART];

    // ------------------------------------------------------------------
    // zone qualification
    // ------------------------------------------------------------------
    wire logic zones_in_window = &(zone_in_window_i | ~zone_enabled_i);
    wire logic zones_at_setpt  = &(zone_at_setpoint_i | ~zone_enabled_i);
    wire logic heat_ready      = state_reg == melter_io_pkg::HEAT_ACTIVE;
    wire logic air_ok          = heat_cmd & zones_in_window & heat_ready;
    wire logic pump_cmd        = (manual_pump | pump_auto_reg) & air_ok;
    wire logic at_temp         = heat_cmd & zones_at_setpt;

    // ------------------------------------------------------------------
    // heat sequence
    // ------------------------------------------------------------------
    wire logic soak_done = soak_cnt_reg >= SOAK_CYCLES - 1;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            melter_io_pkg::HEAT_OFF: begin
                if (heat_cmd) begin
                    state_next = melter_io_pkg::HEAT_WARMUP;
                end
            end
            melter_io_pkg::HEAT_WARMUP: begin
                if (zones_at_setpt) begin
                    state_next = melter_io_pkg::HEAT_SOAK;
                end
            end
            melter_io_pkg::HEAT_SOAK: begin
                if (!zones_in_window) begin
                    state_next = melter_io_pkg::HEAT_WARMUP;
                end else if (soak_done) begin
                    state_next = melter_io_pkg::HEAT_ACTIVE;
                end
            end
            melter_io_pkg::HEAT_ACTIVE: begin
                if (!zones_in_window) begin
                    state_next = melter_io_pkg::HEAT_WARMUP;
                end
            end
        endcase
        if (!heat_cmd) begin
            state_next = melter_io_pkg::HEAT_OFF;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg    <= melter_io_pkg::HEAT_OFF;
            soak_cnt_reg <= '0;
        end else begin
            state_reg    <= state_next;
            soak_cnt_reg <= (state_reg == melter_io_pkg::HEAT_SOAK && !soak_done) ? soak_cnt_reg + 32'h1 : 32'h0;
        end
    end

    // ------------------------------------------------------------------
    // autostart and unit changeover
    // ------------------------------------------------------------------
    wire logic other_unit     = ~active_unit_reg;
    wire logic cur_drum_empty = drum_empty_i[active_unit_reg];
    wire logic cur_drum_low   = drum_low_i[active_unit_reg];
    wire logic changeover     = ~ext_ctrl & ctrl_reg[melter_io_pkg::CTRL_CHANGEOVER]
                              & cur_drum_empty & ~drum_empty_i[other_unit];

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pump_auto_reg   <= 1'b0;
            active_unit_reg <= 1'b0;
        end else begin
            if (!heat_cmd || !autostart_en) begin
                pump_auto_reg <= 1'b0;
            end else if (at_temp && !at_temp_reg) begin
                pump_auto_reg <= 1'b1;
            end
            if (changeover) begin
                active_unit_reg <= other_unit;
            end
        end
    end

    // ------------------------------------------------------------------
    // status encoding
    // ------------------------------------------------------------------
    wire logic [1:0] run_code = pump_cmd ? melter_io_pkg::RUN_PUMP_ON :
                                at_temp  ? melter_io_pkg::RUN_AT_TEMP :
                                heat_cmd ? melter_io_pkg::RUN_HEAT_ON :
                                           melter_io_pkg::RUN_IDLE;
    wire logic [1:0] err_code = alarm_i        ? melter_io_pkg::ERR_ALARM :
                                cur_drum_empty ? melter_io_pkg::ERR_DRUM_EMPTY :
                                cur_drum_low   ? melter_io_pkg::ERR_DRUM_LOW :
                                                 melter_io_pkg::ERR_NONE;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            run_state_reg   <= melter_io_pkg::RUN_IDLE;
            error_state_reg <= melter_io_pkg::ERR_NONE;
            heater_reg      <= 1'b0;
            setback_reg     <= 1'b0;
            air_reg         <= 1'b0;
            pump_reg        <= 1'b0;
        end else begin
            run_state_reg   <= run_code;
            error_state_reg <= err_code;
            heater_reg      <= heat_cmd;
            setback_reg     <= setback_cmd;
            air_reg         <= air_ok;
            pump_reg        <= pump_cmd;
        end
    end

    // ------------------------------------------------------------------
    // interrupt events
    // ------------------------------------------------------------------
    wire logic [melter_io_pkg::EVENTS-1:0] events = {
        ext_ctrl ^ ext_reg,
        changeover,
        cur_drum_empty & ~empty_reg,
        alarm_i & ~alarm_reg,
        at_temp & ~at_temp_reg
    };

    always_comb begin
        irq_status_next = irq_status_reg;
        if (wr_irqc) begin
            irq_status_next = irq_status_reg & ~pwdata_i[melter_io_pkg::EVENTS-1:0];
        end
        irq_status_next = irq_status_next | events;
    end

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            irq_status_reg <= melter_io_pkg::IRQ_RESET;
            ext_reg        <= 1'b0;
            alarm_reg      <= 1'b0;
            empty_reg      <= 1'b0;
            at_temp_reg    <= 1'b0;
        end else begin
            irq_status_reg <= irq_status_next;
            ext_reg        <= ext_ctrl;
            alarm_reg      <= alarm_i;
            empty_reg      <= cur_drum_empty;
            at_temp_reg    <= at_temp;
        end
    end

    // ------------------------------------------------------------------
    // register file
    // ------------------------------------------------------------------
    wire logic [31:0] status_word = {20'h0, 1'b0, zones_at_setpt, zones_in_window, active_unit_reg,
                                     ext_ctrl, error_state_reg, run_state_reg, state_reg, 1'b0};
    wire logic [31:0] diag_word   = {20'h0, pump_reg, air_reg, setback_reg, heater_reg,
                                     error_state_reg, run_state_reg,
                                     external_control_request_in_i, pump_req_i, setback_req_i, heat_req_i};
    wire logic [31:0] rd_word     = hit_ctrl   ? {27'h0, ctrl_reg} :
                                    hit_status ? status_word :
                                    hit_diag   ? diag_word :
                                    hit_irqs   ? {27'h0, irq_status_reg} :
                                    hit_irqe   ? {27'h0, irq_enable_reg} :
                                                 32'h0;

    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            ctrl_reg       <= melter_io_pkg::CTRL_RESET;
            irq_enable_reg <= melter_io_pkg::IRQ_RESET;
            prdata_reg     <= 32'h0;
            pslverr_reg    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg <= pwdata_i[melter_io_pkg::CTRL_W-1:0];
            end
            if (wr_irqe) begin
                irq_enable_reg <= pwdata_i[melter_io_pkg::EVENTS-1:0];
            end
            if (setup_phase) begin
                prdata_reg  <= pwrite_i ? 32'h0 : rd_word;
                pslverr_reg <= ~mapped;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign prdata_o           = prdata_reg;
    assign pready_o           = 1'b1;
    assign pslverr_o          = pslverr_reg & psel_i & penable_i;
    assign run_state_o        = run_state_reg;
    assign error_state_o      = error_state_reg;
    assign heater_enable_o    = heater_reg;
    assign setback_o          = setback_reg;
    assign air_motor_enable_o = air_reg;
    assign pump_on_o          = pump_reg;
    assign active_unit_o      = active_unit_reg;
    assign irq_o              = |(irq_status_reg & irq_enable_reg);

endmodule : plc_discrete_io_status_encoder

/* File: dv/plc_model.sv */
// Purpose: external controller driving the command input connector
// Assumes: commands are taken from the bench just after a rising edge
// Notes:   levels hold until the next command
module plc_model (
    input  wire logic       clk_i,
    input  wire logic [3:0] cmd_i,
    output logic            heat_req_o,
    output logic            setback_req_o,
    output logic            pump_req_o,
    output logic            ext_req_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // bit order ext, pump, setback, heat
    always @(posedge clk_i) begin
        {ext_req_o, pump_req_o, setback_req_o, heat_req_o} <= cmd_i;
    end
endmodule : plc_model

/* File: dv/plc_io_asserts.sv */
// Purpose: port-level checks of the status encoder
// Assumes: registered outputs follow inputs one cycle later
// Notes:   bound to the status encoder module above
module plc_io_asserts (
    input wire logic        clk_i,
    input wire logic        rstn_i,
    input wire logic        heat_req_i,
    input wire logic        setback_req_i,
    input wire logic        external_control_request_in_i,
    input wire logic [13:0] zone_enabled_i,
    input wire logic [13:0] zone_in_window_i,
    input wire logic [1:0]  drum_low_i,
    input wire logic [1:0]  drum_empty_i,
    input wire logic        alarm_i,
    input wire logic [1:0]  run_state_o,
    input wire logic [1:0]  error_state_o,
    input wire logic        heater_enable_o,
    input wire logic        setback_o,
    input wire logic        air_motor_enable_o,
    input wire logic        pump_on_o,
    input wire logic        active_unit_o,
    input wire logic        irq_o
);
    wire logic all_win = &(zone_in_window_i | ~zone_enabled_i);
    wire logic ext     = external_control_request_in_i;
    wire logic quiet   = !alarm_i && drum_low_i == 2'h0 && drum_empty_i == 2'h0;
    wire logic empty2  = !alarm_i && drum_empty_i == 2'h3;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_reset_open: assert property (!$past(rstn_i) |-> {run_state_o, error_state_o, heater_enable_o, setback_o,
        air_motor_enable_o, pump_on_o, irq_o} == 9'h000) else $error("outputs not open after reset");
    a_heat_follow: assert property ($past(rstn_i) && $past(ext) |-> heater_enable_o == $past(heat_req_i))
        else $error("heater does not follow request");
    a_setback_follow: assert property ($past(rstn_i) && $past(ext) |-> setback_o == $past(setback_req_i))
        else $error("setback does not follow request");
    a_err_alarm: assert property ($past(rstn_i) && $past(alarm_i) |-> error_state_o == 2'h3)
        else $error("alarm not encoded");
    a_err_empty: assert property ($past(rstn_i) && $past(empty2) |-> error_state_o == 2'h2)
        else $error("drum empty not encoded");
    a_err_none: assert property ($past(rstn_i) && $past(quiet) |-> error_state_o == 2'h0)
        else $error("error without cause");
    a_run_idle: assert property ($past(rstn_i) && $past(ext) && !$past(heat_req_i) |-> run_state_o == 2'h0 && !pump_on_o)
        else $error("run state without heat");
    a_air_window: assert property (air_motor_enable_o |-> $past(all_win) && heater_enable_o)
        else $error("air motor outside window");
    a_pump_lock: assert property (pump_on_o |-> air_motor_enable_o && run_state_o == 2'h3)
        else $error("pump without interlock");
    a_unit_hold: assert property ($past(rstn_i) && $past(ext) |-> $stable(active_unit_o))
        else $error("changeover under external control");
    c_pump: cover property (run_state_o == 2'h3);
    c_alarm: cover property (error_state_o == 2'h3);
    c_irq: cover property (irq_o);
endmodule : plc_io_asserts
bind plc_discrete_io_status_encoder plc_io_asserts u_plc_io_asserts (.*);

/* File: dv/plc_discrete_io_status_encoder_tb.sv */
// Purpose: self-checking bench of the status encoder
// Assumes: short soak count, zero-wait APB
// Notes:   expectations come from the run and error tables
module plc_discrete_io_status_encoder_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned SOAK = 8;
    logic        clk_i = 1'b0, rstn_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, alarm_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00, rv;
    logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
    logic        pready_o, pslverr_o, er, heat_req_i, setback_req_i, pump_req_i, external_control_request_in_i;
    logic [3:0]  cmd = 4'h0;
    logic [13:0] zone_enabled_i = 14'h3fff, zone_in_window_i = 14'h0000, zone_at_setpoint_i = 14'h0000;
    logic [1:0]  drum_low_i = 2'h0, drum_empty_i = 2'h0, run_state_o, error_state_o;
    logic        heater_enable_o, setback_o, air_motor_enable_o, pump_on_o, active_unit_o, irq_o;
    int          n_fail = 0, n_checks = 0;
    always #2 clk_i = ~clk_i;
    plc_discrete_io_status_encoder #(.SOAK_CYCLES(SOAK)) u_plc_discrete_io_status_encoder (.*);
    plc_model u_plc_model (.clk_i(clk_i), .cmd_i(cmd), .heat_req_o(heat_req_i), .setback_req_o(setback_req_i),
        .pump_req_o(pump_req_i), .ext_req_o(external_control_request_in_i));
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= w;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            @(posedge clk_i);
            if (pready_o === 1'b1) begin
                rd = prdata_o;
                er = pslverr_o;
                psel_i    <= 1'b0;
                penable_i <= 1'b0;
                @(posedge clk_i);
                return;
            end
        end
        n_fail++;
        summarize();
    endtask : apb
    // ------------------------------------------------------------------
    // reference model
    // ------------------------------------------------------------------
    function automatic logic [1:0] run_m(input int heat, input int atsp, input int pump);
        return pump ? 2'h3 : (heat && atsp) ? 2'h2 : heat ? 2'h1 : 2'h0;
    endfunction : run_m
    function automatic logic [1:0] err_m(input int al, input int em, input int lo);
        return al ? 2'h3 : em ? 2'h2 : lo ? 2'h1 : 2'h0;
    endfunction : err_m
    task automatic pins(input int n, input logic [1:0] run, input logic [1:0] err, input logic irq);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
        cmp({30'h0, run_state_o}, {30'h0, run}, "run state");
        cmp({30'h0, error_state_o}, {30'h0, err}, "error state");
        cmp({31'h0, irq_o}, {31'h0, irq}, "irq");
        @(posedge clk_i);
    endtask : pins
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        summarize();
    end
    initial begin
        void'($urandom(32'h8a2c76bf));
        repeat (8) @(posedge clk_i);
        rstn_i <= 1'b1;
        pins(0, 2'h0, 2'h0, 1'b0);
        apb(1'b0, melter_io_pkg::CTRL_OFS, 32'h0);
        cmp(rd, 32'h0, "ctrl reset");
        apb(1'b0, 8'h40, 32'h0);
        cmp({er, rd[30:0]}, 32'h80000000, "unmapped");
        apb(1'b1, melter_io_pkg::IRQ_ENABLE_OFS, 32'h1f);
        apb(1'b1, melter_io_pkg::CTRL_OFS, 32'h4);
        pins(0, run_m(1, 0, 0), 2'h0, 1'b0);
        cmd <= 4'h8;
        pins(3, 2'h0, 2'h0, 1'b1);
        apb(1'b0, melter_io_pkg::IRQ_STATUS_OFS, 32'h0);
        cmp(rd, 32'h10, "ext event");
        apb(1'b1, melter_io_pkg::IRQ_CLEAR_OFS, 32'h10);
        pins(0, 2'h0, 2'h0, 1'b0);
        cmd <= 4'h9;
        pins(3, run_m(1, 0, 0), 2'h0, 1'b0);
        zone_at_setpoint_i <= 14'h3fff;
        zone_in_window_i   <= 14'h3fff;
        cmd <= 4'hd;
        pins(SOAK + 8, run_m(1, 1, 1), 2'h0, 1'b1);
        apb(1'b0, melter_io_pkg::STATUS_OFS, 32'h0);
        cmp({30'h0, rd[2:1]}, 32'h3, "active heat state");
        cmd <= 4'ha;
        pins(3, 2'h0, 2'h0, 1'b1);
        cmp({31'h0, setback_o}, 32'h1, "setback on");
        cmd <= 4'h8;
        apb(1'b1, melter_io_pkg::IRQ_CLEAR_OFS, 32'h1f);
        cmp({31'h0, setback_o}, 32'h0, "setback off");
        apb(1'b1, melter_io_pkg::IRQ_ENABLE_OFS, 32'h0);
        for (int k = 0; k < 24; k++) begin
            rv = 8'($urandom);
            alarm_i      <= rv[0] & rv[1];
            drum_low_i   <= rv[3:2];
            drum_empty_i <= rv[5:4];
            pins(1, 2'h0, err_m(rv[0] & rv[1], rv[4], rv[2]), 1'b0);
            cmp({31'h0, active_unit_o}, 32'h0, "unit held");
        end
        alarm_i      <= 1'b0;
        drum_empty_i <= 2'h0;
        drum_low_i   <= 2'h0;
        apb(1'b1, melter_io_pkg::IRQ_CLEAR_OFS, 32'h1f);
        apb(1'b1, melter_io_pkg::IRQ_ENABLE_OFS, 32'h2);
        alarm_i <= 1'b1;
        pins(2, 2'h0, 2'h3, 1'b1);
        apb(1'b1, melter_io_pkg::IRQ_ENABLE_OFS, 32'h0);
        pins(0, 2'h0, 2'h3, 1'b0);
        apb(1'b1, melter_io_pkg::IRQ_CLEAR_OFS, 32'h2);
        apb(1'b0, melter_io_pkg::IRQ_STATUS_OFS, 32'h0);
        cmp(rd & 32'h2, 32'h0, "alarm cleared");
        apb(1'b1, melter_io_pkg::CTRL_OFS, 32'h1);
        alarm_i <= 1'b0;
        cmd     <= 4'h0;
        apb(1'b1, melter_io_pkg::CTRL_OFS, 32'h5);
        pins(SOAK + 8, run_m(1, 1, 1), 2'h0, 1'b0);
        apb(1'b0, melter_io_pkg::DIAG_OFS, 32'h0);
        cmp(rd, 32'h00000d30, "diag pump active");
        apb(1'b1, melter_io_pkg::CTRL_OFS, 32'h2);
        drum_empty_i <= 2'h1;
        pins(2, 2'h0, 2'h0, 1'b0);
        cmp({31'h0, active_unit_o}, 32'h1, "unit changed over");
        summarize();
    end
endmodule : plc_discrete_io_status_encoder_tb
